// *** shared/ipp_pkg.sv ***
/*
 Constants and field layout for the indirect peek/poke unit.
 Assumes a bus front end that decodes word commands into one-cycle strobes.
*/
package ipp_pkg;
	// ***************************************
	// command codes of the three bus registers
	// ***************************************
	localparam logic [7:0] IPP_CODE_POINTER = 8'hd0;
	localparam logic [7:0] IPP_CODE_DATA0 = 8'hd1;
	localparam logic [7:0] IPP_CODE_DATA1 = 8'hd2;

	// ***************************************
	// pointer register layout
	// ***************************************
	localparam int IPP_PTR_RSVD_BIT = 15;
	localparam int IPP_PTR_ID_BIT = 14;
	localparam int IPP_PTR_PAGE_HI = 13;
	localparam int IPP_PTR_PAGE_LO = 9;
	localparam int IPP_PTR_LOC_HI = 8;
	localparam logic [4:0] IPP_PAGE_MAX = 5'h07;
	localparam logic [8:0] IPP_PTR_RST = 9'h000;
	localparam logic [4:0] IPP_PAGE_RST = 5'h00;
	localparam logic [14:0] IPP_LAST_RST = 15'h0000;

	// ***************************************
	// special locations and pointer words
	// ***************************************
	localparam logic [8:0] IPP_LOC_FLOG = 9'h0ee;
	localparam logic [8:0] IPP_LOC_STAT0 = 9'h02c;
	localparam logic [8:0] IPP_LOC_STAT1 = 9'h02d;
	localparam logic [15:0] IPP_POKE_EN0 = 16'h0bf6;
	localparam logic [15:0] IPP_POKE_DIS0 = 16'h01f6;
	localparam logic [15:0] IPP_POKE_EN1 = 16'h4bf6;
	localparam logic [15:0] IPP_POKE_DIS1 = 16'h41f6;

	// ***************************************
	// event-record walk and status word
	// ***************************************
	localparam logic [15:0] IPP_FLOG_LEN_WORD = 16'h00ff;
	localparam int unsigned IPP_FLOG_WORDS = 128;
	localparam int IPP_ST_PEEK_FAIL = 0;
	localparam int IPP_ST_POKE_FAIL = 1;
	localparam int IPP_PORTS = 2;
endpackage

// *** hdl/ipp_port_ctx.sv ***
/*
 Per-port cached pointer, page, block walk position and status flags.
 Assumes all strobes are one-cycle pulses on the same clock.
*/
`timescale 1ns/1ps
module ipp_port_ctx #(
	parameter int unsigned FLOG_WORDS = ipp_pkg::IPP_FLOG_WORDS
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// controls
	input wire logic ptr_ld,
	input wire logic [8:0] ptr_val,
	input wire logic [4:0] page_val,
	input wire logic poke_on,
	input wire logic poke_off,
	input wire logic clr_en,
	input wire logic rd_adv,
	input wire logic abort,
	input wire logic poke_done,
	input wire logic poke_ok,
	// state
	output logic [8:0] ptr,
	output logic [4:0] page,
	output logic [7:0] idx,
	output logic poke_en,
	output logic peek_fail,
	output logic poke_fail,
	output logic blk_active
);
	import ipp_pkg::*;

	// one past the last buffer word; the walk parks here
	localparam logic [7:0] IDX_END = 8'(FLOG_WORDS + 1);

	logic [8:0] ptr_q, ptr_d;
	logic [4:0] page_q, page_d;
	logic [7:0] idx_q, idx_d;
	logic en_q, en_d, pkf_q, pkf_d, pof_q, pof_d;
	wire new_blk = ptr_ld && (ptr_val == IPP_LOC_FLOG);

	assign blk_active = (ptr_q == IPP_LOC_FLOG) && (idx_q != 8'h00) && (idx_q < IDX_END);

	always_comb begin
		ptr_d = ptr_ld ? ptr_val : ptr_q;
		page_d = ptr_ld ? page_val : page_q;
		idx_d = idx_q;
		if (ptr_ld) begin
			idx_d = 8'h00;
		end else if (rd_adv && (idx_q < IDX_END)) begin
			idx_d = idx_q + 8'h01;
		end
		// abort set beats the clear from a fresh walk
		pkf_d = (abort && blk_active) ? 1'b1 : (new_blk ? 1'b0 : pkf_q);
		pof_d = poke_done ? !poke_ok : pof_q;
		en_d = en_q;
		if (clr_en) begin
			en_d = 1'b0;
		end else if (poke_on) begin
			en_d = 1'b1;
		end else if (poke_off) begin
			en_d = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ptr_q <= IPP_PTR_RST;
			page_q <= IPP_PAGE_RST;
			idx_q <= 8'h00;
			en_q <= 1'b0;
			pkf_q <= 1'b0;
			pof_q <= 1'b0;
		end else begin
			ptr_q <= ptr_d;
			page_q <= page_d;
			idx_q <= idx_d;
			en_q <= en_d;
			pkf_q <= pkf_d;
			pof_q <= pof_d;
		end
	end

	assign ptr = ptr_q;
	assign page = page_q;
	assign idx = idx_q;
	assign poke_en = en_q;
	assign peek_fail = pkf_q;
	assign poke_fail = pof_q;
endmodule

// *** hdl/ipp_top.sv ***
/*
 Indirect peek/poke unit: pointer register, two data ports, status words.
 Assumes a bus front end delivering decoded word commands as strobes and an
 internal location file with a combinational read and a write strobe.
*/
`timescale 1ns/1ps
module ipp_top #(
	parameter int unsigned FLOG_WORDS = ipp_pkg::IPP_FLOG_WORDS
) (
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RST_N,
	// decoded bus command
	input wire logic CMD_WR,
	input wire logic CMD_RD,
	input wire logic [7:0] CMD_CODE,
	input wire logic [15:0] CMD_WDATA,
	output logic RSP_HIT,
	output logic RSP_VALID,
	output logic [15:0] RSP_DATA,
	// watchdog reset pin
	input wire logic WATCHDOG_INPUT,
	// internal location file
	output logic [8:0] LOC_ADDR,
	output logic [2:0] LOC_PAGE,
	input wire logic [15:0] LOC_RDATA,
	input wire logic LOC_LEGAL,
	input wire logic LOC_BYTE,
	input wire logic LOC_WRITABLE,
	output logic POKE_STB,
	output logic [8:0] POKE_ADDR,
	output logic [2:0] POKE_PAGE,
	output logic [15:0] POKE_DATA,
	// event-record buffer
	output logic [7:0] FLOG_WORD_IDX,
	input wire logic [15:0] FLOG_WORD,
	input wire logic FLOG_EE_WRITE,
	input wire logic FLOG_STORE,
	input wire logic FLOG_STD_BLOCK_RD
);
	import ipp_pkg::*;

	// ***************************************
	// elaboration check
	// ***************************************
	// the walk index is eight bits wide and parks one past the end
	if (FLOG_WORDS < 1 || FLOG_WORDS > 253) begin : g_bad
		$error("FLOG_WORDS out of range");
	end

	localparam logic [7:0] IDX_END = 8'(FLOG_WORDS + 1);

	// ***************************************
	// watchdog pin synchroniser and edge
	// ***************************************
	logic wdi_s1_q, wdi_s2_q, wdi_s3_q;
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			wdi_s1_q <= 1'b0;
			wdi_s2_q <= 1'b0;
			wdi_s3_q <= 1'b0;
		end else begin
			wdi_s1_q <= WATCHDOG_INPUT;
			wdi_s2_q <= wdi_s1_q;
			wdi_s3_q <= wdi_s2_q;
		end
	end
	wire wdi_evt = wdi_s2_q && !wdi_s3_q;

	// ***************************************
	// command decode
	// ***************************************
	wire is_ptr = (CMD_CODE == IPP_CODE_POINTER);
	wire is_d0 = (CMD_CODE == IPP_CODE_DATA0);
	wire is_d1 = (CMD_CODE == IPP_CODE_DATA1);
	wire is_data = is_d0 || is_d1;
	wire wr_ptr = CMD_WR && is_ptr;
	wire on0 = wr_ptr && (CMD_WDATA == IPP_POKE_EN0);
	wire off0 = wr_ptr && (CMD_WDATA == IPP_POKE_DIS0);
	wire on1 = wr_ptr && (CMD_WDATA == IPP_POKE_EN1);
	wire off1 = wr_ptr && (CMD_WDATA == IPP_POKE_DIS1);
	// poke control words are commands, not targets, so they leave the caches alone
	wire special = on0 || off0 || on1 || off1;
	wire wr_id = CMD_WDATA[IPP_PTR_ID_BIT];
	wire [8:0] wr_loc = CMD_WDATA[IPP_PTR_LOC_HI:0];
	wire [4:0] wr_page = CMD_WDATA[IPP_PTR_PAGE_HI:IPP_PTR_PAGE_LO];
	wire abort = FLOG_EE_WRITE || FLOG_STORE || FLOG_STD_BLOCK_RD;

	assign RSP_HIT = is_ptr || is_data;

	// ***************************************
	// per-port contexts
	// ***************************************
	logic [8:0] ptr_a [IPP_PORTS];
	logic [4:0] page_a [IPP_PORTS];
	logic [7:0] idx_a [IPP_PORTS];
	logic [IPP_PORTS-1:0] en_a, pkf_a, pof_a, act_a;
	logic [IPP_PORTS-1:0] ld_a, adv_a, done_a, on_a, off_a, sel_a;
	logic poke_ok;

	assign sel_a = {is_d1, is_d0};
	assign on_a = {on1, on0};
	assign off_a = {off1, off0};

	for (genvar i = 0; i < IPP_PORTS; i++) begin : g_port
		assign ld_a[i] = wr_ptr && !special && (wr_id == 1'(i));
		assign adv_a[i] = CMD_RD && sel_a[i] && (ptr_a[i] == IPP_LOC_FLOG);
		assign done_a[i] = CMD_WR && sel_a[i];
		ipp_port_ctx #(
			.FLOG_WORDS(FLOG_WORDS)
		) u_ctx (
			.clk(CLK_SYS),
			.rst_n(RST_N),
			.ptr_ld(ld_a[i]),
			.ptr_val(wr_loc),
			.page_val(wr_page),
			.poke_on(on_a[i]),
			.poke_off(off_a[i]),
			.clr_en(wdi_evt),
			.rd_adv(adv_a[i]),
			.abort(abort),
			.poke_done(done_a[i]),
			.poke_ok(poke_ok),
			.ptr(ptr_a[i]),
			.page(page_a[i]),
			.idx(idx_a[i]),
			.poke_en(en_a[i]),
			.peek_fail(pkf_a[i]),
			.poke_fail(pof_a[i]),
			.blk_active(act_a[i])
		);
	end

	// ***************************************
	// selected port and location lookup
	// ***************************************
	// the port's own page drives the lookup, never the normal page
	wire [8:0] cur_ptr = is_d1 ? ptr_a[1] : ptr_a[0];
	wire [4:0] cur_page = is_d1 ? page_a[1] : page_a[0];
	wire [7:0] cur_idx = is_d1 ? idx_a[1] : idx_a[0];
	wire page_ok = (cur_page <= IPP_PAGE_MAX);
	wire loc_flog = (cur_ptr == IPP_LOC_FLOG);
	wire loc_st0 = (cur_ptr == IPP_LOC_STAT0);
	wire loc_st1 = (cur_ptr == IPP_LOC_STAT1);
	wire loc_internal = loc_flog || loc_st0 || loc_st1;

	assign LOC_ADDR = cur_ptr;
	assign LOC_PAGE = cur_page[2:0];
	// walk position 0 is the length word, so the buffer index lags by one
	assign FLOG_WORD_IDX = cur_idx - 8'h01;

	// ***************************************
	// read data selection
	// ***************************************
	logic [14:0] last_ptr_q;
	wire [15:0] st0_word = {14'h0000, pof_a[0], pkf_a[0]};
	wire [15:0] st1_word = {14'h0000, pof_a[1], pkf_a[1]};
	wire [15:0] loc_word = LOC_BYTE ? {8'h00, LOC_RDATA[7:0]} : LOC_RDATA;
	wire [15:0] blk_word = (cur_idx == 8'h00) ? IPP_FLOG_LEN_WORD :
		((cur_idx < IDX_END) ? FLOG_WORD : 16'h0000);
	wire [15:0] ext_word = (page_ok && LOC_LEGAL) ? loc_word : 16'h0000;
	wire [15:0] data_word = loc_flog ? blk_word :
		(loc_st0 ? st0_word : (loc_st1 ? st1_word : ext_word));
	wire [15:0] rd_word = is_ptr ? {1'b0, last_ptr_q} : data_word;

	// ***************************************
	// poke path
	// ***************************************
	wire cur_en = is_d1 ? en_a[1] : en_a[0];
	// status and block locations are peek-only
	assign poke_ok = cur_en && page_ok && LOC_LEGAL && LOC_WRITABLE && !loc_internal;
	wire poke_go = CMD_WR && is_data && poke_ok;
	wire [15:0] poke_word = LOC_BYTE ? {8'h00, CMD_WDATA[7:0]} : CMD_WDATA;

	// ***************************************
	// output registers
	// ***************************************
	logic rsp_valid_q;
	logic [15:0] rsp_data_q;
	logic poke_stb_q;
	logic [8:0] poke_addr_q;
	logic [2:0] poke_page_q;
	logic [15:0] poke_data_q;

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			last_ptr_q <= IPP_LAST_RST;
			rsp_valid_q <= 1'b0;
			rsp_data_q <= 16'h0000;
		end else begin
			if (wr_ptr) begin
				last_ptr_q <= CMD_WDATA[14:0];
			end
			rsp_valid_q <= CMD_RD && RSP_HIT;
			if (CMD_RD && RSP_HIT) begin
				rsp_data_q <= rd_word;
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			poke_stb_q <= 1'b0;
			poke_addr_q <= 9'h000;
			poke_page_q <= 3'h0;
			poke_data_q <= 16'h0000;
		end else begin
			poke_stb_q <= poke_go;
			if (poke_go) begin
				poke_addr_q <= cur_ptr;
				poke_page_q <= cur_page[2:0];
				poke_data_q <= poke_word;
			end
		end
	end

	assign RSP_VALID = rsp_valid_q;
	assign RSP_DATA = rsp_data_q;
	assign POKE_STB = poke_stb_q;
	assign POKE_ADDR = poke_addr_q;
	assign POKE_PAGE = poke_page_q;
	assign POKE_DATA = poke_data_q;

	// ***************************************
	// checks
	// ***************************************
	property p_ptr_rsvd;
		@(posedge CLK_SYS) disable iff (!RST_N)
		CMD_RD && is_ptr |=> RSP_VALID && !RSP_DATA[15];
	endproperty
	a_ptr_rsvd: assert property (p_ptr_rsvd) else $error("pointer bit 15 not zero");

	property p_sel0;
		@(posedge CLK_SYS) disable iff (!RST_N)
		wr_ptr && !special && !wr_id |=> ptr_a[0] == $past(wr_loc) && $stable(ptr_a[1]);
	endproperty
	a_sel0: assert property (p_sel0) else $error("port 0 pointer not cached");

	property p_page1;
		@(posedge CLK_SYS) disable iff (!RST_N)
		wr_ptr && !special && wr_id |=> page_a[1] == $past(wr_page) && $stable(page_a[0]);
	endproperty
	a_page1: assert property (p_page1) else $error("port 1 page not cached");

	property p_byte;
		@(posedge CLK_SYS) disable iff (!RST_N)
		CMD_RD && is_data && !loc_internal && LOC_BYTE |=> RSP_DATA[15:8] == 8'h00;
	endproperty
	a_byte: assert property (p_byte) else $error("byte peek upper byte set");

	property p_len;
		@(posedge CLK_SYS) disable iff (!RST_N)
		CMD_RD && is_d0 && ptr_a[0] == IPP_LOC_FLOG && idx_a[0] == 8'h00
		|=> RSP_DATA == IPP_FLOG_LEN_WORD && idx_a[0] == 8'h01;
	endproperty
	a_len: assert property (p_len) else $error("length word wrong");

	property p_end;
		@(posedge CLK_SYS) disable iff (!RST_N)
		CMD_RD && is_d0 && ptr_a[0] == IPP_LOC_FLOG && idx_a[0] == IDX_END
		|=> RSP_DATA == 16'h0000 && idx_a[0] == IDX_END;
	endproperty
	a_end: assert property (p_end) else $error("read past end not zero");

	property p_poke_off;
		@(posedge CLK_SYS) disable iff (!RST_N)
		CMD_WR && is_d0 && !en_a[0] |=> !POKE_STB && pof_a[0];
	endproperty
	a_poke_off: assert property (p_poke_off) else $error("poke while disabled");

	property p_poke_ok;
		@(posedge CLK_SYS) disable iff (!RST_N)
		// back-to-back pokes are legal, so the strobe may only stay up behind another poke
		poke_go |=> POKE_STB && POKE_ADDR == $past(cur_ptr) && POKE_DATA == $past(poke_word)
			&& !($past(is_d1) ? pof_a[1] : pof_a[0]) ##1 (!POKE_STB || $past(poke_go));
	endproperty
	a_poke_ok: assert property (p_poke_ok) else $error("poke strobe wrong");

	property p_en0;
		@(posedge CLK_SYS) disable iff (!RST_N)
		on0 && !wdi_evt |=> en_a[0] && !$past(ld_a[0]);
	endproperty
	a_en0: assert property (p_en0) else $error("port 0 enable missed");

	property p_dis1;
		@(posedge CLK_SYS) disable iff (!RST_N)
		off1 |=> !en_a[1] && $stable(ptr_a[1]);
	endproperty
	a_dis1: assert property (p_dis1) else $error("port 1 disable missed");

	property p_hold;
		@(posedge CLK_SYS) disable iff (!RST_N)
		en_a[0] && !off0 && !wdi_evt |=> en_a[0];
	endproperty
	a_hold: assert property (p_hold) else $error("enable dropped");

	property p_abort;
		@(posedge CLK_SYS) disable iff (!RST_N)
		// a fresh walk right after the abort may legally clear the flag again
		abort && act_a[0] ##1 !ld_a[0] |-> pkf_a[0] ##1 pkf_a[0];
	endproperty
	a_abort: assert property (p_abort) else $error("abort not flagged");

	property p_other;
		@(posedge CLK_SYS) disable iff (!RST_N)
		(CMD_RD || CMD_WR) && !RSP_HIT |=> !RSP_VALID && !POKE_STB && $stable(idx_a[0]) && $stable(idx_a[1]);
	endproperty
	a_other: assert property (p_other) else $error("ordinary command disturbed unit");
endmodule

// *** bench/ipp_loc_model.sv ***
/*
 Behavioural internal location file and event-record buffer.
 Assumes the unit drives address and page combinationally and pokes with a one-cycle strobe.
*/
`timescale 1ns/1ps
module ipp_loc_model (
	// clock
	input wire logic clk,
	// location file
	input wire logic [8:0] loc_addr,
	input wire logic [2:0] loc_page,
	output logic [15:0] loc_rdata,
	output logic loc_legal,
	output logic loc_byte,
	output logic loc_writable,
	input wire logic poke_stb,
	input wire logic [8:0] poke_addr,
	input wire logic [2:0] poke_page,
	input wire logic [15:0] poke_data,
	// event-record buffer
	input wire logic [7:0] flog_idx,
	output logic [15:0] flog_word
);
	logic [15:0] mem [4096];
	logic [4095:0] seen_q = '0;
	wire [11:0] rd_key = {loc_page, loc_addr};

	// ***************************************
	// location map
	// ***************************************
	// upper half of the address space does not exist; 0x10..0x1f are bytes, 0x90..0x9f read-only
	assign loc_legal = ~loc_addr[8];
	assign loc_byte = loc_addr[7:4] == 4'h1;
	assign loc_writable = loc_addr[7:4] != 4'h9;
	// full word even for byte places, so the unit must clear the upper byte itself
	assign loc_rdata = seen_q[rd_key] ? mem[rd_key] : {5'h1a, loc_page, loc_addr[7:0]};
	always @(posedge clk) begin
		if (poke_stb) begin
			mem[{poke_page, poke_addr}] <= poke_data;
			seen_q[{poke_page, poke_addr}] <= 1'b1;
		end
	end
	assign flog_word = {~flog_idx, flog_idx};
endmodule

// *** bench/testbench.sv ***
/*
 Self-checking bench for the indirect peek/poke unit.
 Assumes the location model beside it and the package command codes.
*/
`timescale 1ns/1ps
module testbench;
	import ipp_pkg::*;
	localparam int unsigned NW = 4;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cmd_wr = 1'b0;
	logic cmd_rd = 1'b0;
	logic [7:0] cmd_code = 8'h00;
	logic [15:0] cmd_wdata = 16'h0000;
	logic watchdog_input = 1'b0;
	logic ev_ee = 1'b0;
	logic ev_st = 1'b0;
	logic ev_bk = 1'b0;
	logic rsp_hit, rsp_valid, loc_legal, loc_byte, loc_wr, poke_stb;
	logic [15:0] rsp_data, loc_rdata, poke_data, flog_word;
	logic [8:0] loc_addr, poke_addr;
	logic [2:0] loc_page, poke_page;
	logic [7:0] flog_idx;
	int failures = 0;
	int compares = 0;
	int cycles = 0;

	always #25 clk = ~clk;

	ipp_top #(.FLOG_WORDS(NW)) u_ipp_top (.CLK_SYS(clk), .RST_N(rst_n), .CMD_WR(cmd_wr), .CMD_RD(cmd_rd),
		.CMD_CODE(cmd_code), .CMD_WDATA(cmd_wdata), .RSP_HIT(rsp_hit), .RSP_VALID(rsp_valid),
		.RSP_DATA(rsp_data), .WATCHDOG_INPUT(watchdog_input), .LOC_ADDR(loc_addr), .LOC_PAGE(loc_page),
		.LOC_RDATA(loc_rdata), .LOC_LEGAL(loc_legal), .LOC_BYTE(loc_byte), .LOC_WRITABLE(loc_wr),
		.POKE_STB(poke_stb), .POKE_ADDR(poke_addr), .POKE_PAGE(poke_page), .POKE_DATA(poke_data),
		.FLOG_WORD_IDX(flog_idx), .FLOG_WORD(flog_word), .FLOG_EE_WRITE(ev_ee), .FLOG_STORE(ev_st),
		.FLOG_STD_BLOCK_RD(ev_bk));

	ipp_loc_model u_ipp_loc_model (.clk(clk), .loc_addr(loc_addr), .loc_page(loc_page),
		.loc_rdata(loc_rdata), .loc_legal(loc_legal), .loc_byte(loc_byte), .loc_writable(loc_wr),
		.poke_stb(poke_stb), .poke_addr(poke_addr), .poke_page(poke_page), .poke_data(poke_data),
		.flog_idx(flog_idx), .flog_word(flog_word));

	// ***************************************
	// shared helpers
	// ***************************************
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic results;
		$display("failures %0d compares %0d", failures, compares);
		if (failures == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// sized from about 90 operations of two cycles each
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			results();
		end
	end

	function automatic logic [15:0] dflt(input logic [2:0] pg, input logic [8:0] a);
		return {5'h1a, pg, a[7:0]};
	endfunction

	// an idle edge before each strobe keeps every assignment in its own time step
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		@(posedge clk);
		#2;
		cmd_code = c;
		cmd_wdata = d;
		cmd_wr = 1'b1;
		@(posedge clk);
		#2;
		cmd_wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] c, input logic [15:0] exp);
		@(posedge clk);
		#2;
		cmd_code = c;
		cmd_rd = 1'b1;
		@(posedge clk);
		#2;
		cmd_rd = 1'b0;
		chk({15'h0000, rsp_valid}, 16'h0001);
		chk(rsp_data, exp);
	endtask

	task automatic peek(input logic [15:0] p, input logic [7:0] c, input logic [15:0] exp);
		wr(IPP_CODE_POINTER, p);
		rd(c, exp);
	endtask

	task automatic miss;
		@(posedge clk);
		#2;
		cmd_code = 8'h20;
		cmd_rd = 1'b1;
		#1;
		chk({15'h0000, rsp_hit}, 16'h0000);
		@(posedge clk);
		#2;
		cmd_rd = 1'b0;
		chk({15'h0000, rsp_valid}, 16'h0000);
	endtask

	task automatic poke(input logic [7:0] c, input logic [15:0] d, input logic s, input logic [8:0] a,
			input logic [2:0] pg, input logic [15:0] dd);
		wr(c, d);
		chk({15'h0000, poke_stb}, {15'h0000, s});
		if (s) begin
			chk({7'h00, poke_addr}, {7'h00, a});
			chk({13'h0000, poke_page}, {13'h0000, pg});
			chk(poke_data, dd);
		end
	endtask

	task automatic ev(input int k);
		@(posedge clk);
		#2;
		{ev_bk, ev_st, ev_ee} = 3'(1 << k);
		@(posedge clk);
		#2;
		{ev_bk, ev_st, ev_ee} = 3'h0;
	endtask

	// ***************************************
	// scenarios
	// ***************************************
	task automatic t_reset;
		chk({14'h0000, rsp_valid, poke_stb}, 16'h0000);
		chk(rsp_data, 16'h0000);
		rd(IPP_CODE_POINTER, 16'h0000);
	endtask

	task automatic t_pointer;
		wr(IPP_CODE_POINTER, 16'hbe20);
		rd(IPP_CODE_POINTER, 16'h3e20);
		rd(IPP_CODE_DATA0, 16'h0000);
		wr(IPP_CODE_POINTER, 16'h0a20);
		wr(IPP_CODE_POINTER, 16'h4610);
		rd(IPP_CODE_DATA0, dflt(3'h5, 9'h020));
		rd(IPP_CODE_DATA1, 16'h0010);
		peek(16'h0120, IPP_CODE_DATA0, 16'h0000);
	endtask

	task automatic t_poke;
		wr(IPP_CODE_POINTER, 16'h0a20);
		poke(IPP_CODE_DATA0, 16'h1234, 1'b0, 9'h000, 3'h0, 16'h0000);
		peek(16'h002c, IPP_CODE_DATA0, 16'h0002);
		wr(IPP_CODE_POINTER, 16'h0a20);
		wr(IPP_CODE_POINTER, IPP_POKE_EN0);
		poke(IPP_CODE_DATA0, 16'h1234, 1'b1, 9'h020, 3'h5, 16'h1234);
		peek(16'h002c, IPP_CODE_DATA0, 16'h0000);
		peek(16'h0a20, IPP_CODE_DATA0, 16'h1234);
		wr(IPP_CODE_POINTER, 16'h0090);
		poke(IPP_CODE_DATA0, 16'h0001, 1'b0, 9'h000, 3'h0, 16'h0000);
		wr(IPP_CODE_POINTER, 16'h002c);
		poke(IPP_CODE_DATA0, 16'h0000, 1'b0, 9'h000, 3'h0, 16'h0000);
		rd(IPP_CODE_DATA0, 16'h0002);
		wr(IPP_CODE_POINTER, IPP_POKE_DIS0);
		wr(IPP_CODE_POINTER, 16'h0a20);
		poke(IPP_CODE_DATA0, 16'h4321, 1'b0, 9'h000, 3'h0, 16'h0000);
		wr(IPP_CODE_POINTER, IPP_POKE_EN1);
		wr(IPP_CODE_POINTER, 16'h4610);
		poke(IPP_CODE_DATA1, 16'h5555, 1'b1, 9'h010, 3'h3, 16'h0055);
		peek(16'h402d, IPP_CODE_DATA1, 16'h0000);
		peek(16'h4610, IPP_CODE_DATA1, 16'h0055);
		wr(IPP_CODE_POINTER, IPP_POKE_DIS1);
		poke(IPP_CODE_DATA1, 16'h7777, 1'b0, 9'h000, 3'h0, 16'h0000);
		peek(16'h402d, IPP_CODE_DATA1, 16'h0002);
	endtask

	task automatic t_watchdog;
		wr(IPP_CODE_POINTER, IPP_POKE_EN0);
		peek(16'h0a20, IPP_CODE_DATA0, 16'h1234);
		miss();
		poke(IPP_CODE_DATA0, 16'h00aa, 1'b1, 9'h020, 3'h5, 16'h00aa);
		@(posedge clk);
		#2;
		watchdog_input = 1'b1;
		repeat (3) @(posedge clk);
		#2;
		watchdog_input = 1'b0;
		repeat (3) @(posedge clk);
		poke(IPP_CODE_DATA0, 16'h00bb, 1'b0, 9'h000, 3'h0, 16'h0000);
	endtask

	task automatic t_walk;
		wr(IPP_CODE_POINTER, 16'h00ee);
		rd(IPP_CODE_DATA0, IPP_FLOG_LEN_WORD);
		for (int i = 0; i < NW; i++) begin
			rd(IPP_CODE_DATA0, {~8'(i), 8'(i)});
			miss();
			peek(16'h4020, IPP_CODE_DATA1, dflt(3'h0, 9'h020));
		end
		rd(IPP_CODE_DATA0, 16'h0000);
		rd(IPP_CODE_DATA0, 16'h0000);
		peek(16'h002c, IPP_CODE_DATA0, 16'h0002);
	endtask

	task automatic t_abort;
		wr(IPP_CODE_POINTER, 16'h00ee);
		ev(2);
		peek(16'h002c, IPP_CODE_DATA0, 16'h0002);
		for (int k = 0; k < 3; k++) begin
			wr(IPP_CODE_POINTER, 16'h00ee);
			rd(IPP_CODE_DATA0, IPP_FLOG_LEN_WORD);
			rd(IPP_CODE_DATA0, 16'hff00);
			ev(k);
			peek(16'h002c, IPP_CODE_DATA0, 16'h0003);
		end
		peek(16'h002d, IPP_CODE_DATA0, 16'h0002);
	endtask

	initial begin
		repeat (6) @(posedge clk);
		#2;
		rst_n = 1'b1;
		t_reset();
		t_pointer();
		t_poke();
		t_watchdog();
		t_walk();
		t_abort();
		results();
	end
endmodule
